// >>> dv/homing_checker.sv
// port assertions for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module homing_checker (
   // sequencer ports, grouped to keep the file short
   input wire logic clk, sys_rst, start, origin_sw, fwd_limit, index_pulse, busy, done, error,
   input wire logic [3:0] method_sel,
   input wire logic [2:0] speed_sel
);
   logic [3:0] mth_r;
   wire go = start && !busy && (method_sel == 4'h9 || method_sel == 4'hA);
   always_ff @(posedge clk) if (start && !busy) mth_r <= method_sel;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_start_high: assert property (go && !origin_sw |=> speed_sel == 3'h1)
      else $error("bad first speed");
   a_start_low: assert property (go && origin_sw |=> speed_sel == 3'h2)
      else $error("bad first speed");
   a_limit_turn: assert property (speed_sel == 3'h1 && fwd_limit && !origin_sw |=>
      speed_sel == 3'h3) else $error("no turn at limit");
   a_rise_slow: assert property (speed_sel inside {3'h1, 3'h3} && $rose(origin_sw) |=>
      speed_sel == 3'h2) else $error("no slow on rise");
   a_m9_turn: assert property (mth_r == 4'h9 && speed_sel == 3'h2 && $fell(origin_sw) |=>
      speed_sel == 3'h4) else $error("no reverse on fall");
   a_m10_keep: assert property (mth_r == 4'hA && speed_sel == 3'h2 && $fell(origin_sw) |=>
      speed_sel == 3'h2) else $error("speed left on fall");
   a_m10_early: assert property (mth_r == 4'hA && busy && origin_sw && index_pulse |=>
      busy) else $error("stopped too early");
   a_done_stop: assert property ($rose(done) |-> speed_sel == 3'h0 && !busy &&
      $past(index_pulse)) else $error("bad stop");
endmodule : homing_checker
`default_nettype wire

// >>> dv/homing_sequencer_test.sv
// self-checking bench for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module homing_sequencer_test;
   logic clk = 0, sys_rst = 1, start = 0, load = 1, origin_sw, fwd_limit, index_pulse;
   logic busy, done, error;
   logic [3:0] method_sel = 4'h0;
   logic [2:0] speed_sel;
   logic [9:0] pos, load_pos = 10'h000;
   int err_count = 0, checks_done = 0;
   always #25 clk = ~clk;
   homing_sequencer DUT (.*);
   motor_model motor (.*);
   task automatic wrap_up;
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   // speed changes are packed one per hex digit; lo is the lowest legal stop position
   task automatic home(input logic [3:0] m, input logic [9:0] p, lo, input logic [19:0] seq);
      logic [19:0] acc;
      int n;
      @(negedge clk) load_pos = p;
      load = 1;
      @(negedge clk) load = 0;
      start = 1;
      method_sel = m;
      @(negedge clk) start = 0;
      acc = 20'h0;
      for (n = 0; n < 1000 && done !== 1'b1; n++)
      begin
         if (speed_sel !== acc[2:0]) acc = {acc[15:0], 1'b0, speed_sel};
         @(negedge clk);
      end
      if (n == 1000) err_count++;
      if (n == 1000) wrap_up();
      acc = {acc[15:0], 1'b0, speed_sel};
      `CHK(acc, seq)
      `CHK(pos >= lo && pos <= lo + 10'h002, 1'b1)
   endtask : home
   task automatic bad_method;
      @(negedge clk) start = 1;
      method_sel = 4'h5;
      @(negedge clk) start = 0;
      @(negedge clk) `CHK({error, busy, speed_sel}, 5'h10)
   endtask : bad_method
   task automatic m9_limit;
      home(4'h9, 10'h096, 10'h07E, 20'h13240);
   endtask : m9_limit
   task automatic m10_plain;
      home(4'hA, 10'h000, 10'h0A0, 20'h00120);
   endtask : m10_plain
   task automatic m10_on_origin;
      home(4'hA, 10'h078, 10'h0A0, 20'h00020);
   endtask : m10_on_origin
   task automatic m10_limit;
      home(4'hA, 10'h096, 10'h0A0, 20'h01320);
   endtask : m10_limit
   initial
   begin
      repeat (12) @(negedge clk);
      sys_rst = 0;
      load = 0;
      bad_method();
      m9_limit();
      m10_plain();
      m10_on_origin();
      m10_limit();
      wrap_up();
   end
endmodule : homing_sequencer_test
bind homing_sequencer homing_checker chk (.*);
`default_nettype wire

// >>> dv/motor_model.sv
// axis model: position counter with origin band, forward limit and index marks
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   input wire logic clk, load,
   input wire logic [9:0] load_pos,
   input wire logic [2:0] speed_sel,
   output logic origin_sw, fwd_limit, index_pulse,
   output logic [9:0] pos
);
   // high speed steps two counts, so the band edges are crossed with overshoot
   always_ff @(posedge clk)
      pos <= load ? load_pos : pos + (speed_sel == 3'h1 ? 10'h002 : speed_sel == 3'h2 ? 10'h001 :
         speed_sel == 3'h3 ? 10'h3FE : speed_sel == 3'h4 ? 10'h3FF : 10'h000);
   assign origin_sw = pos >= 10'h064 && pos < 10'h08C;
   assign fwd_limit = pos >= 10'h0C8;
   assign index_pulse = pos[4:0] == 5'h00;
endmodule : motor_model
`default_nettype wire

// >>> hdl/homing_pkg.sv
// constants and types for the homing sequencer (methods 9 and 10)
// Function
// - method 9 case 3 starts at forward high speed, reverses at high speed on the forward limit before the origin, and goes forward low on the origin rising edge.
// - method 9 case 3 switches from forward low to reverse low on the origin falling edge.
// - method 9 case 3 halts on the first index pulse that follows the origin rising edge met in reverse low.
// - method 10 case 1 starts at forward high speed and drops to forward low on the origin rising edge.
// - method 10 case 1 keeps forward low speed through the origin falling edge.
// - method 10 case 1 stops on the first index pulse after the origin falling edge.
// - method 10 case 2 starts at forward low, keeps it past the origin falling edge and stops on the next index pulse.
// - method 10 case 3 starts at forward high, reverses at high speed on the forward limit before the origin, and goes forward low on the origin rising edge.
// - method 10 case 3 keeps forward low through the origin falling edge and halts on the first index pulse after it.
// - method 10 case 3 ends with all motion stopped once that index pulse has been seen.
package homing_pkg;
   // speed command codes on speed_sel
   localparam logic [2:0] SPD_STOP = 3'h0;
   localparam logic [2:0] SPD_FWD_HIGH = 3'h1;
   localparam logic [2:0] SPD_FWD_LOW = 3'h2;
   localparam logic [2:0] SPD_REV_HIGH = 3'h3;
   localparam logic [2:0] SPD_REV_LOW = 3'h4;
   // method codes on method_sel
   localparam logic [3:0] METHOD_9 = 4'h9;
   localparam logic [3:0] METHOD_10 = 4'hA;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FWD_HIGH,
      ST_REV_HIGH,
      ST_FWD_LOW,
      ST_REV_LOW,
      ST_SEEK_INDEX,
      ST_DONE
   } state_e;
endpackage : homing_pkg

// >>> hdl/homing_sequencer.sv
// homing sequencer for return-to-zero methods 9 and 10
`timescale 1ns/1ps
`default_nettype none
module homing_sequencer
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // command
   input wire logic start,
   input wire logic [3:0] method_sel,
   // switches and encoder
   input wire logic origin_sw,
   input wire logic fwd_limit,
   input wire logic index_pulse,
   // motion command and status
   output logic [2:0] speed_sel,
   output logic busy,
   output logic done,
   output logic error
);
   // every register of the block lives in this struct, so the reset value and the
   // hold of each field are written once
   typedef struct packed {
      homing_pkg::state_e st;
      logic m10;
      logic org_d;
      logic [2:0] spd;
      logic done;
      logic err;
   } state_s;

   state_s cur_r;
   state_s cur_nxt;

   // origin switch edges against last cycle's sample
   logic org_rise;
   logic org_fall;
   // command decode, only looked at while idle or done
   logic start_ok;
   logic meth9_sel;
   logic meth10_sel;
   logic meth_bad;
   // one flag per sequencer state
   logic in_idle;
   logic in_fwd_high;
   logic in_rev_high;
   logic in_fwd_low;
   logic in_rev_low;
   logic in_seek;
   logic in_done;
   // events that move the sequence on
   logic turn_at_limit;
   logic slow_on_rise;
   logic arm_on_fall;
   logic turn_on_fall;
   logic arm_on_rise;
   logic stop_on_index;

   assign org_rise = origin_sw & ~cur_r.org_d;
   assign org_fall = ~origin_sw & cur_r.org_d;

   // start is refused while a sequence runs
   assign start_ok = start & (in_idle | in_done);
   assign meth9_sel = (method_sel == homing_pkg::METHOD_9);
   assign meth10_sel = (method_sel == homing_pkg::METHOD_10);
   assign meth_bad = ~meth9_sel & ~meth10_sel;

   assign in_idle = (cur_r.st == homing_pkg::ST_IDLE);
   assign in_fwd_high = (cur_r.st == homing_pkg::ST_FWD_HIGH);
   assign in_rev_high = (cur_r.st == homing_pkg::ST_REV_HIGH);
   assign in_fwd_low = (cur_r.st == homing_pkg::ST_FWD_LOW);
   assign in_rev_low = (cur_r.st == homing_pkg::ST_REV_LOW);
   assign in_seek = (cur_r.st == homing_pkg::ST_SEEK_INDEX);
   assign in_done = (cur_r.st == homing_pkg::ST_DONE);

   // a rising edge wins over the limit in the same cycle: the switch is already reached
   assign turn_at_limit = in_fwd_high & fwd_limit & ~org_rise;
   assign slow_on_rise = (in_fwd_high | in_rev_high) & org_rise;
   // method 10 keeps forward low past the fall, method 9 turns back
   assign arm_on_fall = in_fwd_low & org_fall & cur_r.m10;
   assign turn_on_fall = in_fwd_low & org_fall & ~cur_r.m10;
   // index pulses before the arming edge are ignored
   assign arm_on_rise = in_rev_low & org_rise;
   // a level index input stops the run on its first sampled high cycle
   assign stop_on_index = in_seek & index_pulse;

   // phase map, one row per case:
   //   method 9, limit met:  fwd high, limit, rev high, rise, fwd low, fall, rev low,
   //                         rise, index, stop
   //   method 10, no limit:  fwd high, rise, fwd low, fall, index, stop
   //   method 10, on origin: fwd low, fall, index, stop
   //   method 10, limit met: fwd high, limit, rev high, rise, fwd low, fall, index, stop
   // method 9 without a limit or from the origin falls out of the same states; it is a
   // side effect, not a goal
   // speeds are the five codes of the package, stop included

   always_comb
   begin
      cur_nxt = cur_r;
      cur_nxt.org_d = origin_sw;
      unique case (cur_r.st)
         homing_pkg::ST_IDLE, homing_pkg::ST_DONE:
         begin
            if (start_ok)
            begin
               cur_nxt.done = 1'b0;
               cur_nxt.err = 1'b0;
               cur_nxt.m10 = meth10_sel;
               if (meth_bad)
               begin
                  // no motion on an unknown code; error stands until the next start
                  cur_nxt.err = 1'b1;
                  cur_nxt.st = homing_pkg::ST_DONE;
                  cur_nxt.spd = homing_pkg::SPD_STOP;
               end
               else if (origin_sw)
               begin
                  // origin already active: deceleration point valid
                  cur_nxt.st = homing_pkg::ST_FWD_LOW;
                  cur_nxt.spd = homing_pkg::SPD_FWD_LOW;
               end
               else
               begin
                  // origin not yet seen: approach fast
                  cur_nxt.st = homing_pkg::ST_FWD_HIGH;
                  cur_nxt.spd = homing_pkg::SPD_FWD_HIGH;
               end
            end
         end

         homing_pkg::ST_FWD_HIGH:
         begin
            if (slow_on_rise)
            begin
               cur_nxt.st = homing_pkg::ST_FWD_LOW;
               cur_nxt.spd = homing_pkg::SPD_FWD_LOW;
            end
            else if (turn_at_limit)
            begin
               // limit before origin selects case 3
               cur_nxt.st = homing_pkg::ST_REV_HIGH;
               cur_nxt.spd = homing_pkg::SPD_REV_HIGH;
            end
         end

         homing_pkg::ST_REV_HIGH:
         begin
            // reversing past the switch gives its rising edge as we re-enter it
            if (slow_on_rise)
            begin
               cur_nxt.st = homing_pkg::ST_FWD_LOW;
               cur_nxt.spd = homing_pkg::SPD_FWD_LOW;
            end
         end

         homing_pkg::ST_FWD_LOW:
         begin
            if (arm_on_fall)
            begin
               // speed is left at forward low while the index is sought
               cur_nxt.st = homing_pkg::ST_SEEK_INDEX;
            end
            else if (turn_on_fall)
            begin
               cur_nxt.st = homing_pkg::ST_REV_LOW;
               cur_nxt.spd = homing_pkg::SPD_REV_LOW;
            end
         end

         homing_pkg::ST_REV_LOW:
         begin
            // back onto the switch gives a rising edge; index is armed from there
            if (arm_on_rise)
            begin
               cur_nxt.st = homing_pkg::ST_SEEK_INDEX;
            end
         end

         homing_pkg::ST_SEEK_INDEX:
         begin
            // first index after the arming edge ends the run
            if (stop_on_index)
            begin
               cur_nxt.st = homing_pkg::ST_DONE;
               cur_nxt.spd = homing_pkg::SPD_STOP;
               cur_nxt.done = 1'b1;
            end
         end

         default:
         begin
            // the unused eighth code can only come from an upset; park the motor
            cur_nxt.st = homing_pkg::ST_IDLE;
            cur_nxt.spd = homing_pkg::SPD_STOP;
         end
      endcase
      // reset last so that it overrides any transition in the same cycle
      if (sys_rst)
      begin
         cur_nxt.st = homing_pkg::ST_IDLE;
         cur_nxt.m10 = 1'b0;
         cur_nxt.org_d = 1'b0;
         cur_nxt.spd = homing_pkg::SPD_STOP;
         cur_nxt.done = 1'b0;
         cur_nxt.err = 1'b0;
      end
   end

   // the only clocked process; the synchronous reset is folded into cur_nxt
   always_ff @(posedge clk)
   begin
      cur_r <= cur_nxt;
   end

   // speed, done and error come straight from flip-flops; busy is decoded
   assign speed_sel = cur_r.spd;
   assign busy = ~in_idle & ~in_done;
   assign done = cur_r.done;
   assign error = cur_r.err;
endmodule : homing_sequencer
`default_nettype wire
